// ===== shared/icl_pkg.sv
package icl_pkg;
  localparam int PTR_W       = 32;
  localparam int MEM_ADDR_W  = 26;
  localparam int WORD_W      = 16;
  localparam int TAG_W       = 23;
  localparam int SEGS        = 4;
  localparam int SUBS        = 8;
  localparam int SUB_WORDS   = 4;
  localparam int CACHE_BYTES = 256;
  localparam int SEG_BYTES   = 64;
  localparam int DEPTH       = CACHE_BYTES / (WORD_W / 8);
  localparam int SEG_W       = 2;
  localparam int SUB_W       = 3;
  localparam int WSEL_W      = 2;
  localparam int IDX_W       = SEG_W + SUB_W + WSEL_W;
  // Bit positions within the instruction pointer
  localparam int PTR_ZERO_W  = 4;
  localparam int PTR_WSEL_LO = 4;
  localparam int PTR_SUB_LO  = 6;
  localparam int PTR_TAG_LO  = 9;
  // Reset values
  localparam logic [SEG_W*SEGS-1:0] LRU_RESET     = 8'hE4;
  localparam logic [SUBS-1:0]       PRESENT_RESET = 8'h00;
  localparam logic [TAG_W-1:0]      TAG_RESET     = 23'h000000;

  typedef enum logic [0:0] {
    ICL_IDLE = 1'b0,
    ICL_FILL = 1'b1
  } icl_state_e;
endpackage : icl_pkg

// ===== shared/icl_lru_if.sv
`timescale 1ns/1ns
`default_nettype none
interface icl_lru_if;
  logic                     touch;
  logic [icl_pkg::SEG_W-1:0] touch_seg;
  logic [icl_pkg::SEG_W-1:0] victim;
  modport owner (output touch, output touch_seg, input victim);
  modport stack (input touch, input touch_seg, output victim);
endinterface : icl_lru_if
`default_nettype wire

// ===== logic/icl_lru_stack.sv
`timescale 1ns/1ns
`default_nettype none
module icl_lru_stack (
  input  wire logic   clk,
  input  wire logic   rstn,
  icl_lru_if.stack    lru
);
  // ----------------------------------------
  // Move a segment to the top of the stack
  // ----------------------------------------
  function automatic logic [7:0] icl_promote(input logic [7:0] st, input logic [1:0] seg);
    logic [7:0] res;
    int         pos;
    res = st;
    pos = 3;
    for (int i = 3; i >= 0; i--)
    begin
      if (st[2*i +: 2] == seg)
        pos = i;
    end
    for (int i = 1; i < 4; i++)
    begin
      if (i <= pos)
        res[2*i +: 2] = st[2*(i-1) +: 2];
    end
    res[1:0] = seg;
    return res;
  endfunction : icl_promote

  logic [icl_pkg::SEG_W*icl_pkg::SEGS-1:0] order;
  wire  [icl_pkg::SEG_W*icl_pkg::SEGS-1:0] next_order;

  assign next_order = icl_promote(order, lru.touch_seg);
  assign lru.victim = order[7:6];

  always_ff @(posedge clk)
  begin
    if (!rstn)
      order <= icl_pkg::LRU_RESET;
    else if (lru.touch)
      order <= next_order;
  end
endmodule : icl_lru_stack
`default_nettype wire

// ===== logic/icl_cache.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Instruction pointer is 32 bits, word aligned, low four bits zero.
// - Cache holds 256 bytes of instruction words on chip.
// - Fill and replacement run by themselves, invisible to software.
// - Storage is four independent 64-byte segments.
// - Each segment has a 23-bit tag naming its memory region.
// - Each segment has eight subsegments of four words.
// - Each subsegment has its own present flag.
// - Memory is read only on a miss; hits make no traffic.
// - New segment allocation overwrites the least recently used segment.
// - Four-entry stack of two-bit segment numbers, updated each access.
// - Host flush command invalidates all contents so fetches reload.
// - Each fill access gives a 26-bit address of one 16-bit word.
module icl_cache (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            fetch_req,
  input  wire logic [icl_pkg::PTR_W-1:0]       fetch_pc,
  output logic                                 fetch_valid,
  output logic [icl_pkg::WORD_W-1:0]           fetch_data,
  output logic [icl_pkg::PTR_W-1:0]            instruction_pointer,
  input  wire logic                            flush,
  output logic                                 mem_req,
  output logic [icl_pkg::MEM_ADDR_W-1:0]       mem_addr,
  input  wire logic                            mem_ack,
  input  wire logic [icl_pkg::WORD_W-1:0]      mem_data
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [icl_pkg::WORD_W-1:0]          words [icl_pkg::DEPTH];
  logic [icl_pkg::SEGS-1:0][icl_pkg::TAG_W-1:0] tag;
  logic [icl_pkg::SEGS-1:0]            tag_valid;
  logic [icl_pkg::SEGS-1:0][icl_pkg::SUBS-1:0]  present;
  icl_pkg::icl_state_e                 state;
  logic [icl_pkg::SEG_W-1:0]           fill_seg;
  logic [icl_pkg::SUB_W-1:0]           fill_sub;
  logic [icl_pkg::WSEL_W-1:0]          fill_cnt;
  logic                                fill_abort;

  icl_lru_if lru ();

  icl_lru_stack u_lru (
    .clk  (clk),
    .rstn (rstn),
    .lru  (lru)
  );

  function automatic logic [1:0] icl_first(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (m[i])
        r = i[1:0];
    end
    return r;
  endfunction : icl_first

  // ----------------------------------------
  // Lookup
  // ----------------------------------------
  wire [icl_pkg::TAG_W-1:0]  lk_tag  = fetch_pc[icl_pkg::PTR_W-1:icl_pkg::PTR_TAG_LO];
  wire [icl_pkg::SUB_W-1:0]  lk_sub  = fetch_pc[icl_pkg::PTR_TAG_LO-1:icl_pkg::PTR_SUB_LO];
  wire [icl_pkg::WSEL_W-1:0] lk_wsel = fetch_pc[icl_pkg::PTR_SUB_LO-1:icl_pkg::PTR_WSEL_LO];
  wire [icl_pkg::SEGS-1:0]   tag_hit;

  for (genvar s = 0; s < icl_pkg::SEGS; s++)
  begin : g_match
    assign tag_hit[s] = tag_valid[s] && (tag[s] == lk_tag);
  end

  wire [icl_pkg::SEG_W-1:0] hit_seg = icl_first(tag_hit);
  wire                      any_tag = |tag_hit;
  wire                      hit     = any_tag && present[hit_seg][lk_sub];
  wire                      take    = (state == icl_pkg::ICL_IDLE) && fetch_req && !flush;
  wire                      miss    = take && !hit;
  wire                      alloc   = miss && !any_tag;
  wire [icl_pkg::SEG_W-1:0] target  = any_tag ? hit_seg : lru.victim;
  wire                      last    = (fill_cnt == 2'h3);
  wire                      fill_done = (state == icl_pkg::ICL_FILL) && mem_ack && last;
  wire [icl_pkg::IDX_W-1:0] rd_idx  = {hit_seg, lk_sub, lk_wsel};
  wire [icl_pkg::IDX_W-1:0] wr_idx  = {fill_seg, fill_sub, fill_cnt};

  assign lru.touch     = take;
  assign lru.touch_seg = target;
  assign mem_req       = (state == icl_pkg::ICL_FILL);

  // ----------------------------------------
  // Fetch answer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fetch_valid         <= 1'b0;
      fetch_data          <= 16'h0000;
      instruction_pointer <= 32'h00000000;
    end
    else
    begin
      fetch_valid <= take && hit;
      if (take)
        instruction_pointer <= {fetch_pc[icl_pkg::PTR_W-1:icl_pkg::PTR_ZERO_W], 4'h0};
      if (take && hit)
        fetch_data <= words[rd_idx];
    end
  end

  // ----------------------------------------
  // Fill sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state      <= icl_pkg::ICL_IDLE;
      fill_seg   <= 2'h0;
      fill_sub   <= 3'h0;
      fill_cnt   <= 2'h0;
      fill_abort <= 1'b0;
      mem_addr   <= 26'h0000000;
    end
    else
    begin
      case (state)
        icl_pkg::ICL_IDLE:
        begin
          if (miss)
          begin
            state      <= icl_pkg::ICL_FILL;
            fill_seg   <= target;
            fill_sub   <= lk_sub;
            fill_cnt   <= 2'h0;
            fill_abort <= 1'b0;
            mem_addr   <= {fetch_pc[29:icl_pkg::PTR_SUB_LO], 2'h0};
          end
        end
        icl_pkg::ICL_FILL:
        begin
          if (flush)
            fill_abort <= 1'b1;
          if (mem_ack)
          begin
            fill_cnt      <= fill_cnt + 2'h1;
            mem_addr[1:0] <= mem_addr[1:0] + 2'h1;
            if (last)
              state <= icl_pkg::ICL_IDLE;
          end
        end
        default:
          state <= icl_pkg::ICL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (mem_ack && (state == icl_pkg::ICL_FILL))
      words[wr_idx] <= mem_data;
  end

  // ----------------------------------------
  // Tags and present flags
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tag       <= {icl_pkg::SEGS{icl_pkg::TAG_RESET}};
      tag_valid <= 4'h0;
      present   <= {icl_pkg::SEGS{icl_pkg::PRESENT_RESET}};
    end
    else if (flush)
      present <= {icl_pkg::SEGS{icl_pkg::PRESENT_RESET}};
    else
    begin
      if (alloc)
      begin
        tag[target]       <= lk_tag;
        tag_valid[target] <= 1'b1;
        present[target]   <= icl_pkg::PRESENT_RESET;
      end
      if (fill_done && !fill_abort)
        present[fill_seg][fill_sub] <= 1'b1;
    end
  end
endmodule : icl_cache
`default_nettype wire

// ===== tb/icl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module icl_checker (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        fetch_req,
  input  wire logic [icl_pkg::PTR_W-1:0]      fetch_pc,
  input  wire logic                        fetch_valid,
  input  wire logic [icl_pkg::PTR_W-1:0]      instruction_pointer,
  input  wire logic                        flush,
  input  wire logic                        mem_req,
  input  wire logic [icl_pkg::MEM_ADDR_W-1:0] mem_addr,
  input  wire logic                        mem_ack
);
  // ----------------------------------------
  // Fetch and fill properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    fetch_req && !flush && !mem_req;
  endsequence
  sequence s_last;
    mem_req && mem_ack && mem_addr[1:0] == 2'h3;
  endsequence
  a_ptr_low_zero: assert property (instruction_pointer[3:0] == 4'h0)
    else $error("pointer low bits set");
  a_hit_ptr: assert property (fetch_valid |-> instruction_pointer[31:4] == $past(fetch_pc[31:4]))
    else $error("pointer not the taken address");
  a_take_answer: assert property (s_take |=> fetch_valid != mem_req)
    else $error("take gave no single answer");
  a_valid_cause: assert property (fetch_valid |-> $past(fetch_req && !flush && !mem_req))
    else $error("answer without a take");
  a_fill_cause: assert property ($rose(mem_req) |-> $past(fetch_req && !flush))
    else $error("fill without a take");
  a_fill_base: assert property ($rose(mem_req) |-> mem_addr == {$past(fetch_pc[29:6]), 2'h0})
    else $error("fill base address wrong");
  a_fill_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fill request moved before ack");
  a_addr_step: assert property (mem_req && mem_ack && mem_addr[1:0] != 2'h3 |=> mem_req && mem_addr == $past(mem_addr) + 26'h1)
    else $error("fill address did not step");
  a_flush_no_take: assert property (flush |=> !fetch_valid)
    else $error("fetch taken during flush");
  a_fill_refused: assert property (mem_req |=> !fetch_valid)
    else $error("fetch taken during fill");
  a_fill_end: assert property (s_last |=> !mem_req)
    else $error("fill longer than four words");
endmodule : icl_checker
bind icl_cache icl_checker icl_checker_i (.clk(clk), .rstn(rstn), .fetch_req(fetch_req),
  .fetch_pc(fetch_pc), .fetch_valid(fetch_valid), .instruction_pointer(instruction_pointer),
  .flush(flush), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack));
`default_nettype wire

// ===== tb/icl_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module icl_mem_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [25:0] mem_addr,
  output logic             mem_ack,
  output logic [15:0]      mem_data
);
  logic [1:0] wait_cnt;
  wire  [15:0] word = mem_addr[15:0] ^ 16'h5A3C;
  always_ff @(posedge clk)
  begin
    if (!rstn || !mem_req || mem_ack)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= wait_cnt + 2'h1;
  end
  assign mem_ack  = mem_req && (!slow || wait_cnt == 2'h2);
  assign mem_data = mem_ack ? word : ~word;
endmodule : icl_mem_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct { logic [31:0] pc; int fill; } icl_row_s;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        fetch_req = 1'b0;
  logic [31:0] fetch_pc = 32'h0;
  logic        flush = 1'b0;
  logic        slow = 1'b0;
  logic        fetch_valid, mem_req, mem_ack;
  logic [15:0] fetch_data, mem_data;
  logic [31:0] instruction_pointer;
  logic [25:0] mem_addr;
  int          miscompares = 0;
  int          num_checks = 0;
  int          words = 0;
  icl_row_s    rows [13] = '{'{32'h00000000, 4}, '{32'h0000003F, 0}, '{32'h00000040, 4},
    '{32'h00000200, 4}, '{32'h00000400, 4}, '{32'h00000600, 4}, '{32'h00000010, 0},
    '{32'h00000800, 4}, '{32'h00000050, 0}, '{32'h00000200, 4}, '{32'h00000400, 4},
    '{32'h00000000, 0}, '{32'hFFFFFFF0, 4}};
  icl_cache icl_cache_i (.clk(clk), .rstn(rstn), .fetch_req(fetch_req), .fetch_pc(fetch_pc),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .instruction_pointer(instruction_pointer),
    .flush(flush), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));
  icl_mem_model icl_mem_model_i (.clk(clk), .rstn(rstn), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));
  // ----------------------------------------
  // Clock, word counter, tasks
  // ----------------------------------------
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (mem_req && mem_ack) words <= words + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic fetch(input logic [31:0] pc, input int fill, input logic s);
    int n;
    int start;
    n = 0;
    start = words;
    @(posedge clk);
    fetch_pc <= pc;
    fetch_req <= 1'b1;
    slow <= s;
    do @(negedge clk); while (fetch_valid !== 1'b1 && ++n < 200);
    check({31'h0, fetch_valid}, 32'h1);
    check({16'h0, fetch_data}, {16'h0, pc[19:4] ^ 16'h5A3C});
    check(instruction_pointer, {pc[31:4], 4'h0});
    check(words - start, fill);
    @(posedge clk);
    fetch_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fetch
  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) fetch(rows[i].pc, rows[i].fill, i[0]);
    @(posedge clk);
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    fetch(32'h00000050, 4, 1'b1);
    fork
      fetch(32'h00000640, 8, 1'b1);
      begin
        @(posedge mem_req);
        @(posedge clk);
        flush <= 1'b1;
        @(posedge clk);
        flush <= 1'b0;
      end
    join
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(instruction_pointer, 32'h0);
    check({6'h0, mem_addr}, 32'h0);
    check({14'h0, mem_req, fetch_valid, fetch_data}, 32'h0);
    fetch(32'h00000600, 4, 1'b0);
    test_done;
  end
  initial
  begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule : testbench
`default_nettype wire
